/* src/res_defs.vh */
// register map, field positions and timing constants of the rail enable sequencer
`ifndef RES_DEFS_VH
`define RES_DEFS_VH
`define RES_ADDR_R5_SEL      8'h14
`define RES_ADDR_R5_DLY      8'h15
`define RES_ADDR_R6_MASK     8'h16
`define RES_SEL_LSB          2
`define RES_SEL_MSB          4
`define RES_MASK_SWB2LA1     1
`define RES_MASK_LOAD_SWITCH_B1        0
`define RES_FALL_LSB         3
`define RES_FALL_MSB         5
`define RES_RISE_LSB         0
`define RES_RISE_MSB         2
`define RES_SEL_WMASK        8'h1f
`define RES_DLY_WMASK        8'h3f
`define RES_SEL_CONTROL_INPUT_1         3'h0
`define RES_SEL_CONTROL_INPUT_2         3'h1
`define RES_SEL_CONTROL_INPUT_5         3'h2
`define RES_SEL_CONTROL_INPUT_4         3'h3
`define RES_SEL_CONTROL_INPUT_3         3'h4
`define RES_SEL_CONTROL_INPUT_3_4       3'h5
`define RES_SEL_CONTROL_INPUT_6         3'h6
`define RES_SEL_ALWAYS       3'h7
`define RES_DLY_MS_0         7'h00
`define RES_DLY_MS_1         7'h02
`define RES_DLY_MS_2         7'h04
`define RES_DLY_MS_3         7'h08
`define RES_DLY_MS_4         7'h10
`define RES_DLY_MS_5         7'h18
`define RES_DLY_MS_6         7'h20
`define RES_DLY_MS_7         7'h40
`define RES_CLK_MHZ          200
`define RES_MS_IN_US         1000
`define RES_CYC_PER_MS       (`RES_CLK_MHZ * `RES_MS_IN_US)
`endif

/* src/res_rail_enable_seq.v */
// enable sequencing for step-down rail 5 (pin select, power-good masks, edge delays) and power-good masks for rail 6
// Overview of operation
// - bits 4:2 of the select register route one control input (000..110 -> 1,2,5,4,3,6; 101 -> 3 and 4).
// - select code 111 feeds a constant one into the control input mux.
// - select register bit 1 masks the switch-b2/linear-a1 power-good for rail 5 when set.
// - select register bit 0 masks the switch-b1 power-good for rail 5 when set.
// - delay register bits 5:3 delay the enable fall by 0,2,4,8,16,24,32,64 ms.
// - delay register bits 2:0 delay the enable rise with the same code table.
// - edge delays need only be within ten percent of nominal.
// - rail 6 mask bit 7 excludes the linear-a3 power-good when set.
// - rail 6 mask bit 6 excludes the linear-a2 power-good when set.
// - rail 6 mask bit 5 excludes the switch-a1 power-good when set.
// - rail 6 mask bit 4 excludes the rail 5 power-good when set.
// - rail 6 mask bit 3 excludes the rail 4 power-good when set.
// - rail 6 mask bits 2,1,0 exclude the rail 3, 2, 1 power-goods when set.
// - all fields are read/write and take their reset values from the programmed defaults.
`timescale 1ns/1ps
`include "res_defs.vh"

module res_rail_enable_seq #(
    parameter integer CYC_PER_MS = `RES_CYC_PER_MS  // clock cycles per millisecond
) (
    input  wire       core_clk,       // 200 MHz clock
    input  wire       resetn,         // synchronous reset, active low
    input  wire       clkEn,          // freezes all state while low
    input  wire [7:0] otpSel,         // programmed default of select/mask register
    input  wire [7:0] otpDly,         // programmed default of delay register
    input  wire [7:0] otpR6Mask,      // programmed default of rail 6 mask register
    input  wire [7:0] regAddr,        // register offset from serial port
    input  wire [7:0] regWrData,      // write data
    input  wire       regWrEn,        // write strobe, one cycle
    input  wire [5:0] ctlPin,         // control inputs 6..1, bit 0 is input 1
    input  wire       pgSwB2LinA1,    // switch-b2/linear-a1 power-good
    input  wire       pgSwB1,         // switch-b1 power-good
    input  wire [7:0] pgRail6Src,     // la3,la2,load_switch_a1,r5,r4,r3,r2,r1 power-goods
    output reg  [7:0] regRdData_q,    // read data, one cycle after address
    output reg        rail5Enable_q,  // internal enable of rail 5
    output reg        rail6PgReady_q  // all unmasked rail 6 power-goods good
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_WAIT = 2'b10;

    reg  [7:0]  selReg_q;
    reg  [7:0]  dlyReg_q;
    reg  [7:0]  r6Mask_q;
    reg         loaded_q;
    reg  [5:0]  ctlMeta_q;
    reg  [5:0]  ctlSync_q;
    reg  [9:0]  pgMeta_q;
    reg  [9:0]  pgSync_q;
    reg  [1:0]  state_q;
    reg  [31:0] cycCnt_q;
    reg  [6:0]  msCnt_q;
    reg         ctlSelected;
    reg  [6:0]  delayMs;
    wire [2:0]  pinSel   = selReg_q[`RES_SEL_MSB:`RES_SEL_LSB];
    wire [2:0]  fallCode = dlyReg_q[`RES_FALL_MSB:`RES_FALL_LSB];
    wire [2:0]  riseCode = dlyReg_q[`RES_RISE_MSB:`RES_RISE_LSB];
    wire        pgR5Ok;
    wire        rail5Target;
    wire        msTick;

    function [6:0] codeToMs;
        input [2:0] code;
        begin
            case (code)
                3'h0:    codeToMs = `RES_DLY_MS_0;
                3'h1:    codeToMs = `RES_DLY_MS_1;
                3'h2:    codeToMs = `RES_DLY_MS_2;
                3'h3:    codeToMs = `RES_DLY_MS_3;
                3'h4:    codeToMs = `RES_DLY_MS_4;
                3'h5:    codeToMs = `RES_DLY_MS_5;
                3'h6:    codeToMs = `RES_DLY_MS_6;
                default: codeToMs = `RES_DLY_MS_7;
            endcase
        end
    endfunction

    // register file, loaded from programmed defaults once after reset release
    always @(posedge core_clk)
    begin
        if (!resetn)
        begin
            selReg_q <= 8'h00;
            dlyReg_q <= 8'h00;
            r6Mask_q <= 8'h00;
            loaded_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (!loaded_q)
            begin
                selReg_q <= otpSel & `RES_SEL_WMASK;
                dlyReg_q <= otpDly & `RES_DLY_WMASK;
                r6Mask_q <= otpR6Mask;
                loaded_q <= 1'b1;
            end
            else if (regWrEn)
            begin
                case (regAddr)
                    `RES_ADDR_R5_SEL:  selReg_q <= regWrData & `RES_SEL_WMASK;
                    `RES_ADDR_R5_DLY:  dlyReg_q <= regWrData & `RES_DLY_WMASK;
                    `RES_ADDR_R6_MASK: r6Mask_q <= regWrData;
                    default:           selReg_q <= selReg_q;
                endcase
            end
        end
    end

    // registered read; unmapped offsets read zero
    always @(posedge core_clk)
    begin
        if (!resetn)
            regRdData_q <= 8'h00;
        else if (clkEn)
        begin
            case (regAddr)
                `RES_ADDR_R5_SEL:  regRdData_q <= selReg_q;
                `RES_ADDR_R5_DLY:  regRdData_q <= dlyReg_q;
                `RES_ADDR_R6_MASK: regRdData_q <= r6Mask_q;
                default:           regRdData_q <= 8'h00;
            endcase
        end
    end

    // two-stage synchronisers for pins and power-good monitors
    always @(posedge core_clk)
    begin
        if (!resetn)
        begin
            ctlMeta_q <= 6'h00;
            ctlSync_q <= 6'h00;
            pgMeta_q  <= 10'h000;
            pgSync_q  <= 10'h000;
        end
        else if (clkEn)
        begin
            ctlMeta_q <= ctlPin;
            ctlSync_q <= ctlMeta_q;
            pgMeta_q  <= {pgRail6Src, pgSwB2LinA1, pgSwB1};
            pgSync_q  <= pgMeta_q;
        end
    end

    // control input mux
    always @*
    begin
        case (pinSel)
            `RES_SEL_CONTROL_INPUT_1:   ctlSelected = ctlSync_q[0];
            `RES_SEL_CONTROL_INPUT_2:   ctlSelected = ctlSync_q[1];
            `RES_SEL_CONTROL_INPUT_5:   ctlSelected = ctlSync_q[4];
            `RES_SEL_CONTROL_INPUT_4:   ctlSelected = ctlSync_q[3];
            `RES_SEL_CONTROL_INPUT_3:   ctlSelected = ctlSync_q[2];
            `RES_SEL_CONTROL_INPUT_3_4: ctlSelected = ctlSync_q[2] & ctlSync_q[3];
            `RES_SEL_CONTROL_INPUT_6:   ctlSelected = ctlSync_q[5];
            default:         ctlSelected = 1'b1;
        endcase
    end

    assign pgR5Ok = (pgSync_q[1] | selReg_q[`RES_MASK_SWB2LA1])
                  & (pgSync_q[0] | selReg_q[`RES_MASK_LOAD_SWITCH_B1]);
    assign rail5Target = ctlSelected & pgR5Ok;

    // delay of the pending edge: rise code when turning on, fall code when turning off
    always @*
    begin
        if (rail5Enable_q)
            delayMs = codeToMs(fallCode);
        else
            delayMs = codeToMs(riseCode);
    end

    // exact cycle count, well inside the allowed tolerance
    assign msTick = (cycCnt_q == CYC_PER_MS - 1);

    // edge delay state machine; a target that reverts during the wait cancels the edge
    always @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state_q       <= ST_IDLE;
            cycCnt_q      <= 32'h0000_0000;
            msCnt_q       <= 7'h00;
            rail5Enable_q <= 1'b0;
        end
        else if (clkEn && loaded_q)
        begin
            case (state_q)
                ST_IDLE:
                begin
                    cycCnt_q <= 32'h0000_0000;
                    msCnt_q  <= 7'h00;
                    if (rail5Target != rail5Enable_q)
                        state_q <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (rail5Target == rail5Enable_q)
                        state_q <= ST_IDLE;
                    else if (msCnt_q >= delayMs)
                    begin
                        rail5Enable_q <= rail5Target;
                        state_q       <= ST_IDLE;
                    end
                    else if (msTick)
                    begin
                        cycCnt_q <= 32'h0000_0000;
                        msCnt_q  <= msCnt_q + 7'h01;
                    end
                    else
                        cycCnt_q <= cycCnt_q + 32'h0000_0001;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // rail 6 power-good qualification: a set mask bit forces that source good
    always @(posedge core_clk)
    begin
        if (!resetn)
            rail6PgReady_q <= 1'b0;
        else if (clkEn)
            rail6PgReady_q <= &(pgSync_q[9:2] | r6Mask_q);
    end

endmodule // res_rail_enable_seq

/* tb/res_checker.sv */
// port assertions for the rail enable sequencer
`timescale 1ns/1ps
module res_checker (
    input logic       core_clk,       // clock
    input logic       resetn,         // sync reset
    input logic       clkEn,          // run enable
    input logic [7:0] regAddr,        // offset
    input logic [7:0] regWrData,      // write data
    input logic       regWrEn,        // write strobe
    input logic [7:0] pgRail6Src,     // rail 6 goods
    input logic [7:0] regRdData_q,    // read data
    input logic       rail5Enable_q,  // rail 5 enable
    input logic       rail6PgReady_q  // rail 6 ready
);
    logic [1:0] upCnt_q;  // enabled edges since reset, saturating
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            upCnt_q <= 2'd0;
        else if (clkEn && upCnt_q != 2'd3)
            upCnt_q <= upCnt_q + 2'd1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence wr_s(a);
        clkEn && regWrEn && regAddr == a && upCnt_q != 2'd0;
    endsequence
    sequence rd_s(a);
        clkEn && !regWrEn && regAddr == a;
    endsequence
    property wr_rd_p(a, m);
        wr_s(a) ##1 rd_s(a) |=> regRdData_q == ($past(regWrData, 2) & m);
    endproperty
    sel_wr_rd_a: assert property (wr_rd_p(8'h14, 8'h1f))
        else $error("select readback wrong");
    dly_wr_rd_a: assert property (wr_rd_p(8'h15, 8'h3f))
        else $error("delay readback wrong");
    mask_wr_rd_a: assert property (wr_rd_p(8'h16, 8'hff))
        else $error("mask readback wrong");
    sel_rsvd_a: assert property (clkEn && regAddr == 8'h14 |=> regRdData_q[7:5] == 3'h0)
        else $error("select spare bits set");
    dly_rsvd_a: assert property (clkEn && regAddr == 8'h15 |=> regRdData_q[7:6] == 2'h0)
        else $error("delay spare bits set");
    unmapped_zero_a: assert property (clkEn && !(regAddr inside {8'h14, 8'h15, 8'h16})
        |=> regRdData_q == 8'h00) else $error("unmapped read not zero");
    r6_all_good_a: assert property ((clkEn && pgRail6Src == 8'hff && upCnt_q == 2'd3)[*3]
        |=> rail6PgReady_q) else $error("rail 6 not ready");
    freeze_hold_a: assert property (!clkEn |=> $stable(rail5Enable_q) && $stable(regRdData_q))
        else $error("outputs moved while frozen");
endmodule // res_checker
bind res_rail_enable_seq res_checker u_chk (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .pgRail6Src(pgRail6Src),
    .regRdData_q(regRdData_q), .rail5Enable_q(rail5Enable_q), .rail6PgReady_q(rail6PgReady_q));

/* tb/res_far_side.sv */
// model of the control pins and power-good monitors
`timescale 1ns/1ps
module res_far_side (
    input  logic       core_clk,     // clock
    input  logic [5:0] ctlSet,       // wanted pin levels
    input  logic [9:0] pgSet,        // wanted goods {b2a1, b1, rail 6}
    output logic [5:0] ctlPin,       // control inputs
    output logic       pgSwB2LinA1,  // switch-b2/linear-a1 good
    output logic       pgSwB1,       // switch-b1 good
    output logic [7:0] pgRail6Src    // rail 6 sources
);
    initial {ctlPin, pgSwB2LinA1, pgSwB1, pgRail6Src} = 16'h0000;
    // monitors settle one edge after a request
    always @(posedge core_clk)
    begin
        ctlPin <= ctlSet;
        {pgSwB2LinA1, pgSwB1, pgRail6Src} <= pgSet;
    end
endmodule // res_far_side

/* tb/rail_enable_sequencing_tb_top.sv */
// self-checking bench for the rail enable sequencer
`timescale 1ns/1ps
module rail_enable_sequencing_tb_top;
    localparam integer CYC = 10;  // shortened millisecond
    logic       core_clk = 1'b0, resetn = 1'b0, clkEn = 1'b1, regWrEn = 1'b0;
    logic [7:0] otp[3], regAddr = 8'h00, regWrData = 8'h00, rdVal, d, m, pg6;
    logic [7:0] wm[4] = '{8'h1f, 8'h3f, 8'hff, 8'h00};
    logic [5:0] ctlSet = 6'h00, ctl, ctlPin;
    logic [9:0] pgSet = 10'h000;
    logic [7:0] pgRail6Src, regRdData_q;
    logic [2:0] sel;
    logic [1:0] m5, pg5;
    logic       pgSwB2LinA1, pgSwB1, rail5Enable_q, rail6PgReady_q;
    int         fail_count = 0, checks_done = 0, n, i, j;
    int         tbl[8] = '{0, 2, 4, 8, 16, 24, 32, 64};
    res_far_side far (.core_clk(core_clk), .ctlSet(ctlSet), .pgSet(pgSet), .ctlPin(ctlPin),
        .pgSwB2LinA1(pgSwB2LinA1), .pgSwB1(pgSwB1), .pgRail6Src(pgRail6Src));
    res_rail_enable_seq #(.CYC_PER_MS(CYC)) dut (.core_clk(core_clk), .resetn(resetn),
        .clkEn(clkEn), .otpSel(otp[0]), .otpDly(otp[1]), .otpR6Mask(otp[2]),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .ctlPin(ctlPin),
        .pgSwB2LinA1(pgSwB2LinA1), .pgSwB1(pgSwB1), .pgRail6Src(pgRail6Src),
        .regRdData_q(regRdData_q), .rail5Enable_q(rail5Enable_q),
        .rail6PgReady_q(rail6PgReady_q));
    initial forever #2.5 core_clk = ~core_clk;
    function automatic logic exp5(input logic [2:0] s, input logic [5:0] p,
        input logic [1:0] mk, input logic [1:0] g);
        logic [7:0] mux;
        mux = {1'b1, p[5], p[2] & p[3], p[2], p[3], p[4], p[1], p[0]};
        return mux[s] & (g[1] | mk[1]) & (g[0] | mk[0]);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= v;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        regAddr <= a;
        settle(2);
        rdVal = regRdData_q;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (30000) @(posedge core_clk);
        fail_count++;
        stop_test;
    end
    initial
    begin
        void'($urandom(32'h01a9));
        foreach (otp[k]) otp[k] <= $urandom;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        settle(2);
        for (i = 0; i < 3; i++)
        begin
            rd(8'h14 + i);
            check(rdVal, otp[i] & wm[i]);
        end
        $display("test reset values done");
        // move the address while frozen: the read data must not follow it
        @(posedge core_clk);
        clkEn <= 1'b0;
        regAddr <= 8'h14;
        repeat (3) @(posedge core_clk);
        clkEn <= 1'b1;
        #1;
        check(regRdData_q, rdVal);
        $display("test clock enable freeze done");
        for (i = 0; i < 16; i++)
        begin
            n = i % 4;
            d = (i < 4) ? 8'hff : $urandom;
            wr(8'h14 + n, d);
            rd(8'h14 + n);
            check(rdVal, d & wm[n]);
        end
        $display("test registers done");
        for (i = 0; i < 24; i++)
        begin
            m = (i < 2) ? 8'h00 : $urandom;
            pg6 = (i == 0) ? 8'hff : (i == 1) ? 8'hfe : $urandom;
            wr(8'h16, m);
            pgSet[7:0] <= pg6;
            settle(6);
            check(rail6PgReady_q, &(pg6 | m));
        end
        $display("test rail 6 masks done");
        wr(8'h15, 8'h00);
        for (i = 0; i < 64; i++)
        begin
            sel = (i < 8) ? i : $urandom;
            m5 = (i < 8) ? 2'h3 : $urandom;
            ctl = $urandom;
            pg5 = $urandom;
            wr(8'h14, {3'h0, sel, m5});
            ctlSet <= ctl;
            pgSet[9:8] <= pg5;
            settle(8);
            check(rail5Enable_q, exp5(sel, ctl, m5, pg5));
        end
        $display("test rail 5 select done");
        wr(8'h14, 8'h03);
        ctlSet <= 6'h00;
        settle(8);
        for (i = 1; i < 8; i++)
        begin
            wr(8'h15, {2'h0, i[2:0], i[2:0]});
            for (j = 1; j >= 0; j--)
            begin
                ctlSet <= {5'h00, j[0]};
                n = 0;
                while (rail5Enable_q !== j[0] && n < 2000)
                begin
                    settle(1);
                    n++;
                end
                check(n >= tbl[i] * CYC * 9 / 10 && n <= tbl[i] * (CYC + 1) * 11 / 10 + 8, 1);
            end
        end
        $display("test edge delays done");
        stop_test;
    end
endmodule // rail_enable_sequencing_tb_top
